// ===== rtl/pmc_map.svh
// offsets-free constant map: reset values, timing counts, trim steps and divider sizes for the power/clock controller
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define PMC_CLK_MHZ          40
`define PMC_WAKE_US          35
`define PMC_WAKE_CYC         (`PMC_WAKE_US * `PMC_CLK_MHZ)
`define PMC_SYNC_STAGES      2
// ----------------------------------------
// oscillator trim: 24 MHz base, 4 MHz steps, 48 MHz top
// ----------------------------------------
`define PMC_OSC_BASE_MHZ     24
`define PMC_OSC_STEP_MHZ     4
`define PMC_OSC_TRIM_RST     3'h0
`define PMC_OSC_TRIM_MAX     3'h6
`define PMC_LF_KHZ           40
// ----------------------------------------
// dividers
// ----------------------------------------
`define PMC_NUM_DIV          4
`define PMC_DIV_W            16
`endif

// ===== rtl/pmc_pkg.sv
// types for the power-mode and clock control block
package pmc_pkg;
    typedef enum logic [1:0] {
        PMC_MODE_ACTIVE = 2'h0,
        PMC_MODE_SLEEP  = 2'h1,
        PMC_MODE_DEEP   = 2'h2
    } pmc_mode_t;

    typedef enum logic [2:0] {
        PMC_ST_HOLD   = 3'h0,
        PMC_ST_ACTIVE = 3'h1,
        PMC_ST_SLEEP  = 3'h2,
        PMC_ST_DEEP   = 3'h3,
        PMC_ST_WAKE   = 3'h4
    } pmc_state_t;

    typedef enum logic [1:0] {
        PMC_SRC_MAIN = 2'h0,
        PMC_SRC_LF   = 2'h1,
        PMC_SRC_EXT  = 2'h2
    } pmc_src_t;
endpackage : pmc_pkg

// ===== rtl/pmc_ctrl.sv
// power-mode sequencer, clock-source switch selects and peripheral dividers
`include "pmc_map.svh"
module pmc_ctrl import pmc_pkg::*; #(
    parameter int NUM_DIV  = `PMC_NUM_DIV,
    parameter int DIV_W    = `PMC_DIV_W,
    parameter int WAKE_CYC = `PMC_WAKE_CYC
) (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   rstn,
    // supply monitor
    input  wire logic                   supply_ok,
    input  wire logic                   brownout,
    // mode requests from the cpu
    input  wire logic                   sleep_req,
    input  wire logic                   deep_req,
    input  wire logic                   wake_event,
    // oscillator control and status
    input  wire logic [2:0]             osc_trim_in,
    input  wire logic                   osc_trim_load,
    input  wire logic                   main_osc_stable,
    output logic      [2:0]             main_osc_trim,
    output logic                        main_osc_en,
    output logic                        low_freq_osc_en,
    // source selection: one-hot gate enables, one per source
    input  wire logic [1:0]             src_req,
    input  wire logic [2:0]             src_ack,
    output logic      [2:0]             src_gate_en,
    // gated clock enables and the wake interrupt
    output logic                        cpu_clk_en,
    output logic                        mem_clk_en,
    output logic                        periph_clk_en,
    output logic                        wakeup_interrupt_unit_en,
    output logic                        wake_irq,
    // dividers
    input  wire logic [NUM_DIV*DIV_W-1:0] div_ratio,
    output logic      [NUM_DIV-1:0]     div_tick,
    // status
    output logic      [1:0]             power_mode,
    output logic                        sys_reset_n
);
    // ----------------------------------------
    // power-mode sequencer
    // ----------------------------------------
    localparam int CNT_W = $clog2(WAKE_CYC + 1);
    pmc_state_t       st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d, wake_len_q, wake_len_d;
    logic             rst_n_q, rst_n_d;
    logic             irq_q, irq_d;

    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        rst_n_d = rst_n_q;
        irq_d   = 1'b0;
        wake_len_d = (st_q == PMC_ST_WAKE) ? wake_len_q + 1'b1 : '0;
        case (st_q)
            PMC_ST_HOLD: begin
                rst_n_d = 1'b0;
                if (supply_ok && !brownout) begin
                    st_d    = PMC_ST_ACTIVE;
                    rst_n_d = 1'b1;
                end
            end
            PMC_ST_ACTIVE: begin
                if (deep_req) begin
                    st_d = PMC_ST_DEEP;
                end else if (sleep_req) begin
                    st_d = PMC_ST_SLEEP;
                end
            end
            PMC_ST_SLEEP: begin
                if (wake_event) begin
                    st_d  = PMC_ST_ACTIVE;
                    irq_d = 1'b1;
                end
            end
            PMC_ST_DEEP: begin
                if (wake_event) begin
                    st_d  = PMC_ST_WAKE;
                    cnt_d = '0;
                    irq_d = 1'b1;
                end
            end
            PMC_ST_WAKE: begin
                cnt_d = cnt_q + 1'b1;
                // timeout bounds the wait even if stable never arrives
                if (main_osc_stable || cnt_q >= CNT_W'(WAKE_CYC - 1)) begin
                    st_d = PMC_ST_ACTIVE;
                end
            end
            default: st_d = PMC_ST_HOLD;
        endcase
        if (brownout || !supply_ok) begin
            st_d    = PMC_ST_HOLD;
            rst_n_d = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q    <= PMC_ST_HOLD;
            cnt_q   <= '0;
            wake_len_q <= '0;
            rst_n_q <= 1'b0;
            irq_q   <= 1'b0;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            wake_len_q <= wake_len_d;
            rst_n_q <= rst_n_d;
            irq_q   <= irq_d;
        end
    end

    // ----------------------------------------
    // clock gate enables, registered
    // ----------------------------------------
    logic       cpu_q, cpu_d, mem_q, mem_d, per_q, per_d, osc_q, osc_d, lf_q, lf_d;
    logic [1:0] mode_q, mode_d;

    always_comb begin
        cpu_d  = (st_d == PMC_ST_ACTIVE);
        mem_d  = (st_d == PMC_ST_ACTIVE);
        per_d  = (st_d == PMC_ST_ACTIVE) || (st_d == PMC_ST_SLEEP);
        osc_d  = (st_d != PMC_ST_DEEP) && (st_d != PMC_ST_HOLD);
        lf_d   = 1'b1;
        case (st_d)
            PMC_ST_SLEEP: mode_d = PMC_MODE_SLEEP;
            PMC_ST_DEEP,
            PMC_ST_WAKE:  mode_d = PMC_MODE_DEEP;
            default:      mode_d = PMC_MODE_ACTIVE;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cpu_q  <= 1'b0;
            mem_q  <= 1'b0;
            per_q  <= 1'b0;
            osc_q  <= 1'b0;
            lf_q   <= 1'b1;
            mode_q <= 2'h0;
        end else begin
            cpu_q  <= cpu_d;
            mem_q  <= mem_d;
            per_q  <= per_d;
            osc_q  <= osc_d;
            lf_q   <= lf_d;
            mode_q <= mode_d;
        end
    end

    // ----------------------------------------
    // oscillator trim
    // ----------------------------------------
    logic [2:0] trim_q, trim_d;

    always_comb begin
        trim_d = trim_q;
        if (osc_trim_load && osc_trim_in <= `PMC_OSC_TRIM_MAX) begin
            trim_d = osc_trim_in;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            trim_q <= `PMC_OSC_TRIM_RST;
        end else begin
            trim_q <= trim_d;
        end
    end

    // ----------------------------------------
    // glitch-free source switch
    // ----------------------------------------
    // acks come from each source domain; double-flop them before use
    logic [2:0] ack_s1_q, ack_s2_q, gate_q, gate_d;
    logic [2:0] want;

    always_comb begin
        case (src_req)
            PMC_SRC_LF:  want = 3'h2;
            PMC_SRC_EXT: want = 3'h4;
            default:     want = 3'h1;
        endcase
        gate_d = gate_q;
        if (want != gate_q) begin
            // drop the old gate first, raise the new one once all acks are low
            if (gate_q != 3'h0) begin
                gate_d = 3'h0;
            end else if (ack_s2_q == 3'h0) begin
                gate_d = want;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ack_s1_q <= 3'h0;
            ack_s2_q <= 3'h0;
            gate_q   <= 3'h1;
        end else begin
            ack_s1_q <= src_ack;
            ack_s2_q <= ack_s1_q;
            gate_q   <= gate_d;
        end
    end

    // ----------------------------------------
    // peripheral dividers, one enable pulse each
    // ----------------------------------------
    logic [NUM_DIV*DIV_W-1:0] dcnt_q, dcnt_d;
    logic [NUM_DIV-1:0]       tick_q, tick_d;

    always_comb begin
        dcnt_d = dcnt_q;
        tick_d = '0;
        for (int i = 0; i < NUM_DIV; i++) begin
            // a ratio of n ticks once every n+1 cpu clocks
            if (!cpu_q) begin
                dcnt_d[i*DIV_W +: DIV_W] = '0;
            end else if (dcnt_q[i*DIV_W +: DIV_W] >= div_ratio[i*DIV_W +: DIV_W]) begin
                dcnt_d[i*DIV_W +: DIV_W] = '0;
                tick_d[i] = 1'b1;
            end else begin
                dcnt_d[i*DIV_W +: DIV_W] = dcnt_q[i*DIV_W +: DIV_W] + 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dcnt_q <= '0;
            tick_q <= '0;
        end else begin
            dcnt_q <= dcnt_d;
            tick_q <= tick_d;
        end
    end

    assign main_osc_trim            = trim_q;
    assign main_osc_en              = osc_q;
    assign low_freq_osc_en          = lf_q;
    assign src_gate_en              = gate_q;
    assign cpu_clk_en               = cpu_q;
    assign mem_clk_en               = mem_q;
    assign periph_clk_en            = per_q;
    assign wakeup_interrupt_unit_en = rst_n_q;
    assign wake_irq                 = irq_q;
    assign div_tick                 = tick_q;
    assign power_mode               = mode_q;
    assign sys_reset_n              = rst_n_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_brownout_reset: assert property (brownout |=> !sys_reset_n) else $error("brownout did not reset");
    a_sleep_gates_cpu: assert property (power_mode == 2'h1 |-> !cpu_clk_en && periph_clk_en)
        else $error("sleep gating wrong");
    a_sleep_wake_fast: assert property (st_q == PMC_ST_SLEEP && wake_event && supply_ok && !brownout
        |=> cpu_clk_en) else $error("sleep wake slow");
    a_deep_osc_off: assert property (st_q == PMC_ST_DEEP |-> !main_osc_en) else $error("osc on in deep");
    // wake_len_q counts cycles spent waiting, so the bound holds for any budget
    a_deep_wake_time: assert property (st_q == PMC_ST_WAKE |-> wake_len_q < CNT_W'(WAKE_CYC))
        else $error("deep wake too long");
    a_wake_waits_stable: assert property ($rose(cpu_clk_en) && $past(st_q) == PMC_ST_WAKE
        |-> $past(main_osc_stable) || $past(cnt_q) >= CNT_W'(WAKE_CYC - 1)) else $error("cpu released early");
    a_gate_one_hot: assert property ($onehot0(src_gate_en)) else $error("two sources gated");
    a_gate_break_first: assert property (src_gate_en != 3'h0 && $changed(src_gate_en)
        |-> $past(src_gate_en) == 3'h0) else $error("make before break");
    a_active_all_on: assert property (st_q == PMC_ST_ACTIVE && $past(st_q) == PMC_ST_ACTIVE
        |-> cpu_clk_en && mem_clk_en && periph_clk_en) else $error("active gated");
    a_trim_range: assert property (main_osc_trim <= `PMC_OSC_TRIM_MAX) else $error("trim range");
    a_div_tick: assert property (cpu_clk_en && $past(cpu_clk_en) && div_ratio[DIV_W-1:0] == 16'h0
        && $stable(div_ratio) |=> div_tick[0]) else $error("divider idle");

    c_sleep_cycle: cover property (st_q == PMC_ST_SLEEP ##[1:20] st_q == PMC_ST_ACTIVE);
    c_deep_cycle:  cover property (st_q == PMC_ST_DEEP ##1 st_q == PMC_ST_WAKE ##[1:1000] st_q == PMC_ST_ACTIVE);
    c_src_switch:  cover property (src_gate_en == 3'h1 ##[1:20] src_gate_en == 3'h4);
    c_brownout:    cover property (st_q == PMC_ST_ACTIVE ##1 st_q == PMC_ST_HOLD);
endmodule : pmc_ctrl

// ===== test/power_mode_clock_control_tb_top.sv
// self-checking bench for the power-mode and clock control block
module power_mode_clock_control_tb_top import pmc_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    // short wake budget keeps the timeout path quick to reach
    localparam int WAKE = 20;
    logic        clock = 1'b0, rstn = 1'b0, supply_ok = 1'b0, brownout = 1'b0;
    logic        sleep_req = 1'b0, deep_req = 1'b0, wake_event = 1'b0;
    logic [2:0]  osc_trim_in = 3'h0, src_ack = 3'h1;
    logic        osc_trim_load = 1'b0, main_osc_stable = 1'b1;
    logic [1:0]  src_req = 2'h0;
    logic [63:0] div_ratio = {16'h0003, 16'h0002, 16'h0001, 16'h0000};
    logic [2:0]  main_osc_trim, src_gate_en;
    logic        main_osc_en, low_freq_osc_en, cpu_clk_en, mem_clk_en, periph_clk_en;
    logic        wakeup_interrupt_unit_en, wake_irq, sys_reset_n;
    logic [3:0]  div_tick;
    logic [1:0]  power_mode;
    int          n_mismatch = 0, n_tests = 0, cyc_count = 0;

    always #12.5 clock = ~clock;

    pmc_ctrl #(.WAKE_CYC(WAKE)) dut (
        .clock(clock), .rstn(rstn), .supply_ok(supply_ok), .brownout(brownout),
        .sleep_req(sleep_req), .deep_req(deep_req), .wake_event(wake_event),
        .osc_trim_in(osc_trim_in), .osc_trim_load(osc_trim_load), .main_osc_stable(main_osc_stable),
        .main_osc_trim(main_osc_trim), .main_osc_en(main_osc_en), .low_freq_osc_en(low_freq_osc_en),
        .src_req(src_req), .src_ack(src_ack), .src_gate_en(src_gate_en),
        .cpu_clk_en(cpu_clk_en), .mem_clk_en(mem_clk_en), .periph_clk_en(periph_clk_en),
        .wakeup_interrupt_unit_en(wakeup_interrupt_unit_en), .wake_irq(wake_irq),
        .div_ratio(div_ratio), .div_tick(div_tick), .power_mode(power_mode), .sys_reset_n(sys_reset_n)
    );

    // ----------------------------------------
    // compare and report
    // ----------------------------------------
    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask : chk_bit

    task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk_vec

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    // the whole run needs under two hundred cycles
    always @(posedge clock) begin
        cyc_count++;
        if (cyc_count == 3000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        @(negedge clock);
        chk_vec(8'(src_gate_en), 8'h01, "gate reset");
        chk_bit(low_freq_osc_en, 1'b1, "lf osc on in reset");
        chk_vec(8'(main_osc_trim), 8'h00, "trim reset");
        @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk_bit(sys_reset_n, 1'b0, "held off without supply");
        chk_bit(cpu_clk_en, 1'b0, "cpu clock off in hold");
        @(posedge clock);
        supply_ok <= 1'b1;
        @(posedge clock);
        @(negedge clock);
        chk_bit(sys_reset_n, 1'b1, "reset released");
        chk_bit(cpu_clk_en & mem_clk_en & periph_clk_en & main_osc_en, 1'b1, "active clocks");
        chk_vec(8'(power_mode), 8'(PMC_MODE_ACTIVE), "active mode");
    endtask : t_reset

    task automatic t_sleep;
        @(posedge clock);
        sleep_req <= 1'b1;
        @(posedge clock);
        sleep_req <= 1'b0;
        @(negedge clock);
        chk_vec(8'(power_mode), 8'(PMC_MODE_SLEEP), "sleep mode");
        chk_bit(cpu_clk_en | mem_clk_en, 1'b0, "cpu gated");
        chk_bit(periph_clk_en, 1'b1, "periph runs in sleep");
        @(posedge clock);
        wake_event <= 1'b1;
        @(posedge clock);
        wake_event <= 1'b0;
        @(negedge clock);
        chk_bit(cpu_clk_en & mem_clk_en & wake_irq, 1'b1, "instant wake");
        chk_vec(8'(power_mode), 8'(PMC_MODE_ACTIVE), "back active");
        @(negedge clock);
        chk_bit(wake_irq, 1'b0, "wake pulse one cycle");
    endtask : t_sleep

    task automatic t_deep(input logic use_stable);
        @(posedge clock);
        deep_req <= 1'b1;
        main_osc_stable <= 1'b0;
        @(posedge clock);
        deep_req <= 1'b0;
        @(negedge clock);
        chk_vec(8'(power_mode), 8'(PMC_MODE_DEEP), "deep mode");
        chk_bit(main_osc_en | cpu_clk_en, 1'b0, "fast osc off");
        chk_bit(wakeup_interrupt_unit_en & low_freq_osc_en, 1'b1, "wake unit alive");
        @(posedge clock);
        wake_event <= 1'b1;
        @(posedge clock);
        wake_event <= 1'b0;
        @(negedge clock);
        chk_bit(main_osc_en & wake_irq, 1'b1, "deep wake starts");
        chk_bit(cpu_clk_en, 1'b0, "cpu gated until stable");
        if (use_stable) begin
            repeat (5) @(negedge clock);
            chk_bit(cpu_clk_en, 1'b0, "still waiting");
            @(posedge clock);
            main_osc_stable <= 1'b1;
            repeat (2) @(posedge clock);
        end else begin
            repeat (WAKE - 3) @(negedge clock);
            chk_bit(cpu_clk_en, 1'b0, "early release");
            repeat (4) @(posedge clock);
        end
        @(negedge clock);
        chk_bit(cpu_clk_en, 1'b1, "wake within budget");
        chk_vec(8'(power_mode), 8'(PMC_MODE_ACTIVE), "deep exit");
        @(posedge clock);
        main_osc_stable <= 1'b1;
    endtask : t_deep

    task automatic t_src(input logic [1:0] req, input logic [2:0] onehot);
        int n;
        n = 0;
        @(posedge clock);
        src_req <= req;
        @(posedge clock);
        @(negedge clock);
        chk_vec(8'(src_gate_en), 8'h00, "break before make");
        @(posedge clock);
        src_ack <= 3'h0;
        while (src_gate_en !== onehot && n < 10) begin
            @(negedge clock);
            n++;
        end
        chk_vec(8'(src_gate_en), 8'(onehot), "new source gate");
        chk_bit(n >= 3, 1'b1, "ack passes two flops");
        @(posedge clock);
        src_ack <= onehot;
    endtask : t_src

    task automatic t_div;
        int cnt [4];
        cnt = '{default: 0};
        repeat (24) begin
            @(negedge clock);
            for (int i = 0; i < 4; i++) begin
                cnt[i] += int'(div_tick[i]);
            end
        end
        for (int i = 0; i < 4; i++) begin
            chk_vec(8'(cnt[i]), 8'(24 / (i + 1)), "divider ticks");
        end
    endtask : t_div

    task automatic t_trim;
        @(posedge clock);
        osc_trim_in <= 3'h6;
        osc_trim_load <= 1'b1;
        @(posedge clock);
        osc_trim_in <= 3'h7;
        @(posedge clock);
        osc_trim_load <= 1'b0;
        @(negedge clock);
        chk_vec(8'(main_osc_trim), 8'h06, "top trim kept, 7 refused");
    endtask : t_trim

    task automatic t_brown;
        @(posedge clock);
        brownout <= 1'b1;
        @(posedge clock);
        brownout <= 1'b0;
        @(negedge clock);
        chk_bit(sys_reset_n | cpu_clk_en, 1'b0, "brown-out reset");
        repeat (3) @(negedge clock);
        chk_bit(sys_reset_n & cpu_clk_en, 1'b1, "recovered");
    endtask : t_brown

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        t_reset();
        t_sleep();
        t_deep(1'b1);
        t_deep(1'b0);
        t_src(2'h2, 3'h4);
        t_src(2'h0, 3'h1);
        t_src(2'h1, 3'h2);
        t_src(2'h3, 3'h1);
        t_div();
        t_trim();
        t_brown();
        report_and_stop();
    end
endmodule : power_mode_clock_control_tb_top
